// ==== core/mnx_consts.svh ====
// Encodings, address constants and reset values for the multiply/negate executor.
`ifndef MNX_CONSTS_SVH
`define MNX_CONSTS_SVH
`define MNX_OP_MULL 8'h0d
`define MNX_OP_MULR 7'h01
`define MNX_OP_NEG 7'h36
`define MNX_OP_NOP_HI 4'hf
`define MNX_WORD_NOP 16'h0000
`define MNX_ACC_SPLIT 8'h80
`define MNX_ACC_LOW_BANK 4'h0
`define MNX_ACC_HIGH_BANK 4'hf
`define MNX_PROD_RST 8'h00
`define MNX_FLAGS_RST 5'h00
`define MNX_ADDR_RST 12'h000
`define MNX_DATA_RST 8'h00
`define MNX_ONE9 9'h001
`define MNX_ONE5 5'h01
`define MNX_PAD_BYTE 8'h00
`define MNX_SIGN_EDGE 8'h80
`define MNX_NIBBLE_ZERO 4'h0
`endif

// ==== core/mnx_pkg.sv ====
// Types shared by the multiply/negate executor files.
package mnx_pkg;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] operand;
   } mnx_instr_t;

   typedef struct packed {
      logic negative;
      logic signedExcess;
      logic zero;
      logic halfCarry;
      logic carry;
   } mnx_flags_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_EXEC = 3'b100
   } mnx_state_t;
endpackage

// ==== core/mnx_negate.sv ====
// Two's-complement negation of one data byte with its arithmetic flags.
`include "mnx_consts.svh"
module mnx_negate (
   // Operand in
   input wire logic [7:0] operand,
   // Result out
   output logic [7:0] result,
   output mnx_pkg::mnx_flags_t flags
);
   import mnx_pkg::*;
   logic [8:0] sum;
   logic [4:0] lowSum;
   // The negation is formed as inverse plus one so the carries fall out of the adders.
   assign sum = {1'b0, ~operand} + `MNX_ONE9;
   assign lowSum = {1'b0, ~operand[3:0]} + `MNX_ONE5;
   assign result = sum[7:0];
   assign flags.negative = sum[7];
   assign flags.signedExcess = operand[7] & sum[7];
   assign flags.zero = (sum[7:0] == `MNX_DATA_RST);
   assign flags.halfCarry = lowSum[4];
   assign flags.carry = sum[8];
endmodule

// ==== core/mnx_exec.sv ====
// Executor for multiply by literal, multiply by register, negate and no-operation words.
// Summary of operation
// RULE1: Opcode 0000 1101 with an 8-bit immediate is multiply by literal.
// RULE2: Multiply by literal stores accumulator times immediate as a full 16-bit product.
// RULE3: Each product's high byte goes to product high, low byte to product low.
// RULE4: Multiplies never touch any flag; no zero, carry or overflow indication.
// RULE5: Opcode 0000 001 plus access bit and address is multiply by register.
// RULE6: Multiply by register stores accumulator times the addressed byte as 16 bits.
// RULE7: Multiplies leave the accumulator and the source register unchanged.
// RULE8: Access bit 0 uses the access bank; 1 uses the bank select value.
// RULE9: Opcode 0110 110 negates the addressed register and updates five arithmetic flags.
// RULE10: Zero words and words with top nibble 1111 complete with no effect.
`include "mnx_consts.svh"
module mnx_exec (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Instruction in
   input wire logic instrValid,
   input mnx_pkg::mnx_instr_t instr,
   input wire logic [7:0] accumulator,
   input wire logic [3:0] bankSelectValue,
   // Data memory
   output logic [11:0] memAddr,
   output logic memRead,
   output logic memWrite,
   output logic [7:0] memWrData,
   input wire logic [7:0] memRdData,
   // Results and status
   output logic [7:0] productHigh,
   output logic [7:0] productLow,
   output mnx_pkg::mnx_flags_t flags,
   output logic busy,
   output logic done,
   output logic foreign
);
   import mnx_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   mnx_state_t state;
   logic accept;
   logic multiplyLiteralOp;
   logic multiplyRegisterOp;
   logic negateRegisterOp;
   logic noOperationOp;
   logic [11:0] operandAddr;
   logic [15:0] literalProduct;
   logic [15:0] registerProduct;
   logic [7:0] accLatch;
   logic isNegate;
   logic [7:0] negResult;
   mnx_flags_t negFlags;

   assign accept = instrValid && (state == ST_IDLE);
   assign multiplyLiteralOp = (instr.opcode == `MNX_OP_MULL); // RULE1
   assign multiplyRegisterOp = (instr.opcode[7:1] == `MNX_OP_MULR); // RULE5
   assign negateRegisterOp = (instr.opcode[7:1] == `MNX_OP_NEG); // RULE9
   assign noOperationOp = (instr == `MNX_WORD_NOP) || (instr.opcode[7:4] == `MNX_OP_NOP_HI); // RULE10

   // The access bank splits at one address: the low half is bank 0, the high half the top bank.
   always_comb begin
      if (instr.opcode[0]) begin
         operandAddr = {bankSelectValue, instr.operand}; // RULE8
      end else if (instr.operand < `MNX_ACC_SPLIT) begin
         operandAddr = {`MNX_ACC_LOW_BANK, instr.operand}; // RULE8
      end else begin
         operandAddr = {`MNX_ACC_HIGH_BANK, instr.operand}; // RULE8
      end
   end

   assign literalProduct = {`MNX_PAD_BYTE, accumulator} * {`MNX_PAD_BYTE, instr.operand}; // RULE2
   assign registerProduct = {`MNX_PAD_BYTE, accLatch} * {`MNX_PAD_BYTE, memRdData}; // RULE6

   mnx_negate negUnit (
      .operand(memRdData),
      .result(negResult),
      .flags(negFlags)
   );

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   // Register operands take a read cycle; the memory answers one cycle after memRead.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         busy <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (accept && (multiplyRegisterOp || negateRegisterOp)) begin
                  state <= ST_READ;
                  busy <= 1'b1;
               end
            end
            ST_READ: begin
               state <= ST_EXEC;
            end
            ST_EXEC: begin
               state <= ST_IDLE;
               busy <= 1'b0;
            end
            default: begin
               state <= ST_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         accLatch <= `MNX_DATA_RST;
         isNegate <= 1'b0;
      end else if (accept) begin
         accLatch <= accumulator;
         isNegate <= negateRegisterOp;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
         foreign <= 1'b0;
      end else begin
         done <= (accept && !multiplyRegisterOp && !negateRegisterOp) || (state == ST_EXEC);
         foreign <= accept && !multiplyLiteralOp && !multiplyRegisterOp && !negateRegisterOp && !noOperationOp;
      end
   end

   // ----------------------------------------
   // Data memory port
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         memAddr <= `MNX_ADDR_RST;
         memRead <= 1'b0;
         memWrite <= 1'b0;
         memWrData <= `MNX_DATA_RST;
      end else begin
         memRead <= accept && (multiplyRegisterOp || negateRegisterOp);
         memWrite <= (state == ST_EXEC) && isNegate; // RULE7 RULE9
         if (accept && (multiplyRegisterOp || negateRegisterOp)) begin
            memAddr <= operandAddr; // RULE8
         end
         if ((state == ST_EXEC) && isNegate) begin
            memWrData <= negResult; // RULE9
         end
      end
   end

   // ----------------------------------------
   // Product pair and flags
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         productHigh <= `MNX_PROD_RST;
         productLow <= `MNX_PROD_RST;
      end else if (accept && multiplyLiteralOp) begin
         productHigh <= literalProduct[15:8]; // RULE2 RULE3
         productLow <= literalProduct[7:0]; // RULE3
      end else if ((state == ST_EXEC) && !isNegate) begin
         productHigh <= registerProduct[15:8]; // RULE6 RULE3
         productLow <= registerProduct[7:0]; // RULE3
      end
   end

   // Only the negate writes flags, so a zero product is silently left unflagged.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags <= `MNX_FLAGS_RST;
      end else if ((state == ST_EXEC) && isNegate) begin
         flags <= negFlags; // RULE9 RULE4
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_LIT_DECODE: assert property (accept && multiplyLiteralOp |=> done && !busy && !memRead) // RULE1
      else $error("literal multiply not completed in one cycle");
   AST_LIT_PRODUCT: assert property (accept && multiplyLiteralOp |=>
      ({productHigh, productLow} == $past(literalProduct))) // RULE2
      else $error("literal product wrong");
   AST_HIGH_LOW: assert property (accept && multiplyLiteralOp |=>
      (productHigh == 8'($past({`MNX_PAD_BYTE, accumulator} * {`MNX_PAD_BYTE, instr.operand}) >> 8))
      && (productLow == $past(literalProduct[7:0]))) // RULE3
      else $error("product bytes swapped or wrong");
   AST_MUL_FLAGS: assert property (accept && (multiplyLiteralOp || multiplyRegisterOp) |=> $stable(flags) [*3]) // RULE4
      else $error("multiply changed flags");
   AST_REG_SEQ: assert property (accept && multiplyRegisterOp |=> memRead && busy ##1 !memRead ##1 done) // RULE5
      else $error("register multiply sequence wrong");
   AST_REG_PRODUCT: assert property ((state == ST_EXEC) && !isNegate |=>
      ({productHigh, productLow} == $past(registerProduct))) // RULE6
      else $error("register product wrong");
   AST_MUL_NO_WRITE: assert property (accept && multiplyRegisterOp |=> !memWrite [*3]) // RULE7
      else $error("multiply wrote data memory");
   AST_BANK_SEL: assert property (accept && (multiplyRegisterOp || negateRegisterOp) && instr.opcode[0] |=>
      (memAddr == {$past(bankSelectValue), $past(instr.operand)})) // RULE8
      else $error("banked address wrong");
   AST_ACCESS_BANK: assert property (accept && (multiplyRegisterOp || negateRegisterOp) && !instr.opcode[0] |=>
      (memAddr[11:8] == (memAddr[7] ? `MNX_ACC_HIGH_BANK : `MNX_ACC_LOW_BANK))) // RULE8
      else $error("access bank address wrong");
   AST_NEGATE: assert property ((state == ST_EXEC) && isNegate |=>
      memWrite && (memWrData == 8'($past(`MNX_DATA_RST - memRdData))) && (flags.zero == (memWrData == `MNX_DATA_RST))
      && (flags.carry == flags.zero)) // RULE9
      else $error("negate result or flags wrong");
   // The excess and half-carry flags are held against the byte that was read, so a wrong sign term in the adder shows up.
   AST_NEG_FLAGS: assert property ((state == ST_EXEC) && isNegate |=>
      (flags.negative == memWrData[7]) && (flags.signedExcess == ($past(memRdData) == `MNX_SIGN_EDGE))
      && (flags.halfCarry == ($past(memRdData[3:0]) == `MNX_NIBBLE_ZERO))) // RULE9
      else $error("negate sign, excess or half carry flag wrong");
   AST_FOREIGN: assert property (accept && !multiplyLiteralOp && !multiplyRegisterOp && !negateRegisterOp &&
      !noOperationOp |=> done && foreign && !memRead && !memWrite && !busy) // RULE10
      else $error("foreign word not completed without effect");
   AST_NOP: assert property (accept && noOperationOp |=>
      done && !memWrite && !memRead && $stable(flags) && $stable(productHigh) && $stable(productLow)) // RULE10
      else $error("no-operation word had an effect");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the multiply/negate executor.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import mnx_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic instrValid = 1'b0;
   mnx_instr_t instr = 16'h0000;
   logic [7:0] accumulator = 8'h00;
   logic [3:0] bankSelectValue = 4'h0;
   logic [7:0] memRdData = 8'h00;
   logic [11:0] memAddr;
   logic memRead;
   logic memWrite;
   logic [7:0] memWrData;
   logic [7:0] productHigh;
   logic [7:0] productLow;
   mnx_flags_t flags;
   logic busy;
   logic done;
   logic foreign;
   int n_fail = 0;
   int num_checks = 0;
   int seed = 72687;
   int expProd = 0;
   int expFlags = 0;
   logic [15:0] tbl [8] = '{16'h0d00, 16'h0200, 16'h0300, 16'h6c00, 16'h6d00, 16'hf000, 16'h0000, 16'h6e00};

   mnx_exec u_dut (.clock(clock), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
      .accumulator(accumulator), .bankSelectValue(bankSelectValue), .memAddr(memAddr),
      .memRead(memRead), .memWrite(memWrite), .memWrData(memWrData), .memRdData(memRdData),
      .productHigh(productHigh), .productLow(productLow), .flags(flags), .busy(busy),
      .done(done), .foreign(foreign));

   always #2.5 clock = ~clock;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One instruction; junk offers a second word while busy, which must be ignored.
   task automatic run(input logic [15:0] w, input logic [7:0] acc, input logic [3:0] bank,
                      input logic [7:0] rd, input logic junk);
      int kind;
      int addr;
      int res;
      int reads;
      int k;
      logic seen;
      kind = (w[15:8] == 8'h0d) ? 1 : (w[15:9] == 7'h01) ? 2 : (w[15:9] == 7'h36) ? 3 :
             (w == 16'h0000 || w[15:12] == 4'hf) ? 0 : 4;
      addr = w[8] ? {bank, w[7:0]} : (w[7] ? {4'hf, w[7:0]} : {4'h0, w[7:0]});
      res = (256 - int'(rd)) & 255;
      if (kind == 1) expProd = int'(acc) * int'(w[7:0]);
      if (kind == 2) expProd = int'(acc) * int'(rd);
      if (kind == 3) expFlags = {res[7], rd == 8'h80, res == 0, rd[3:0] == 4'h0, rd == 8'h00};
      reads = 0;
      @(posedge clock);
      instrValid <= 1'b1;
      instr <= w;
      accumulator <= acc;
      bankSelectValue <= bank;
      memRdData <= ~rd;
      @(posedge clock);
      // Moving the accumulator after accept shows whether the operand was latched.
      instrValid <= junk;
      instr <= 16'h0d55;
      accumulator <= ~acc;
      for (k = 1; k <= 8; k++) begin
         @(negedge clock);
         seen = memRead;
         if (seen === 1'b1) reads++;
         if (seen === 1'b1) chk(memAddr, addr, "address");
         chk(busy, (kind == 2 || kind == 3) && k < 3, "busy");
         if (done === 1'b1) break;
         @(posedge clock);
         instrValid <= 1'b0;
         memRdData <= (seen === 1'b1) ? rd : ~rd;
      end
      chk(k, (kind == 2 || kind == 3) ? 3 : 1, "latency");
      chk(reads, kind == 2 || kind == 3, "read count");
      chk({productHigh, productLow}, expProd, "product");
      chk(flags, expFlags, "flags");
      chk(foreign, kind == 4, "foreign");
      chk(memWrite, kind == 3, "write strobe");
      if (kind == 3) chk(memWrData, res, "negated byte");
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      int i;
      int r;
      logic [15:0] w;
      repeat (16) @(posedge clock);
      chk({productHigh, productLow}, 16'h0000, "reset product");
      rst_n <= 1'b1;
      run(16'h0dc4, 8'he2, 4'h0, 8'h00, 1'b0);
      run(16'h0210, 8'hc4, 4'h5, 8'hb5, 1'b1);
      run(16'h0390, 8'hc4, 4'ha, 8'hff, 1'b1);
      run(16'h6d20, 8'h11, 4'h3, 8'h3a, 1'b0);
      run(16'h6c85, 8'h00, 4'h7, 8'h00, 1'b0);
      run(16'h6c00, 8'h01, 4'h7, 8'h80, 1'b1);
      run(16'h0d00, 8'hff, 4'h0, 8'h00, 1'b0);
      run(16'h0000, 8'h12, 4'h1, 8'h00, 1'b0);
      run(16'hf3a5, 8'h34, 4'h2, 8'h00, 1'b0);
      run(16'h0e12, 8'h56, 4'h3, 8'h00, 1'b0);
      $display("directed test done");
      for (i = 0; i < 300; i++) begin
         r = rnd();
         w = tbl[r[2:0]];
         if (w != 16'h0000) w[7:0] = r[31:24];
         run(w, r[15:8], r[19:16], r[27:20], r[3] && r[2:0] >= 1 && r[2:0] <= 4);
      end
      $display("random test done");
      wrap_up();
   end

   // About 1,000 cycles of traffic are expected; this limit is twenty times that.
   initial begin
      #100000;
      n_fail++;
      wrap_up();
   end
endmodule
